// file: inc/crt_pkg.sv
// Shared constants and types for the cascadable reload countdown timer.
package crt_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] CRT_IDX_T0_CNT_LO = 8'h13;
    localparam logic [7:0] CRT_IDX_T1_CTRL = 8'h14;
    localparam logic [7:0] CRT_IDX_T1_RLD_HI = 8'h15;
    localparam logic [7:0] CRT_IDX_T1_RLD_LO = 8'h16;
    localparam logic [7:0] CRT_IDX_T1_CNT_HI = 8'h17;
    localparam logic [7:0] CRT_IDX_T1_CNT_LO = 8'h18;
    localparam logic [7:0] CRT_IDX_T2_CTRL = 8'h19;
    localparam logic [7:0] CRT_IDX_GLOBAL = 8'h20;
    localparam logic [7:0] CRT_IDX_FLAGS = 8'h21;

    // Field positions of the control, global and flag registers.
    localparam int CRT_BIT_STOP_RX = 7;
    localparam int CRT_BIT_AUTO = 3;
    localparam int CRT_BIT_RUNNING = 5;
    localparam int CRT_BIT_SS_EN = 1;
    localparam int CRT_BIT_UF_FLAG = 0;

    // Values after reset.
    localparam logic [7:0] CRT_CTRL_RST = 8'h00;
    localparam logic [15:0] CRT_RELOAD_RST = 16'h0000;

    // Clock rates in kHz and the divider from carrier to slow tick.
    localparam int CRT_CLK_KHZ = 40000;
    localparam int CRT_CARRIER_KHZ = 13560;
    localparam int CRT_SLOW_DIV = 64;
    localparam int CRT_ACC_W = 16;

    // AXI response codes.
    localparam logic [1:0] CRT_RESP_OKAY = 2'h0;
    localparam logic [1:0] CRT_RESP_SLVERR = 2'h2;

    // Start mode field encoding.
    typedef enum logic [1:0] {
        CRT_START_NONE = 2'h0,
        CRT_START_TX_END = 2'h1,
        CRT_START_TRIM = 2'h2,
        CRT_START_TRIM_UF = 2'h3
    } crt_start_t;

    // Clock source field encoding.
    typedef enum logic [1:0] {
        CRT_CLK_CARRIER = 2'h0,
        CRT_CLK_SLOW = 2'h1,
        CRT_CLK_PREV_UF = 2'h2,
        CRT_CLK_NEXT_UF = 2'h3
    } crt_clksrc_t;

    // Layout of a timer control register.
    typedef struct packed {
        logic stop_on_receive_bit;
        logic reserved_hi;
        crt_start_t start_mode_field;
        logic auto_restart_bit;
        logic reserved_lo;
        crt_clksrc_t clock_source_field;
    } crt_ctrl_t;

    // Events coming from the surrounding frontend logic.
    typedef struct packed {
        logic tx_end;
        logic rx_first_bits;
        logic first_timer_underflow;
        logic third_timer_underflow;
    } crt_events_t;

endpackage

// file: hw/crt_timer.sv
`timescale 1ns/10ps
// What this block does
// - Stop-on-receive halts timer after four bits.
// - Stop-on-receive ignored in either trimming mode.
// - Start mode bits 5:4; 01 starts on transmit end.
// - Mode 10 trims oscillator, no underflow, edge start/stop.
// - Mode 11 trims oscillator with underflow, edge start/stop.
// - Auto-restart set reloads and continues at zero.
// - Auto-restart clear stops timer at zero.
// - Every underflow sets the underflow flag.
// - Clock source 00 carrier, 01 divided clock.
// - Sources 10 and 11 count neighbour timer underflows.
// - Start event copies sixteen-bit reload into counter.
// - Reload writes never disturb a running count.
// - Reload high at 15h, low at 16h.
// - Live count high at 17h, low at 18h.
// - First timer count low byte at 13h.
// - Control at 14h, reserved bits 6 and 2.
// - Third timer control at 19h, same layout.
// - Software writes change running flag only with enable bit set.
module crt_timer
    import crt_pkg::*;
#(
    parameter int TMR_W = 16,
    parameter int SLOW_DIV = CRT_SLOW_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire crt_events_t events,
    input wire logic [7:0] first_timer_count_low_byte,
    input wire logic trim_ref,
    output logic second_timer_underflow_flag,
    output logic second_timer_running_flag,
    output logic second_timer_underflow_pulse,
    output crt_ctrl_t third_timer_control
);

    // The counter and reload path are built for exactly sixteen bits.
    if (TMR_W != 16 || SLOW_DIV < 1) begin : g_bad_param
        $error("crt_timer supports TMR_W of 16 and SLOW_DIV of 1 or more.");
    end

    // Byte address to register index, with the low two bits ignored.
    function automatic logic [7:0] reg_index(input logic [7:0] addr);
        reg_index = {2'h0, addr[7:2]};
    endfunction

    // True when the index names a register of this block.
    function automatic logic reg_mapped(input logic [7:0] idx);
        reg_mapped = (idx >= CRT_IDX_T0_CNT_LO && idx <= CRT_IDX_T2_CTRL) ||
            idx == CRT_IDX_GLOBAL || idx == CRT_IDX_FLAGS;
    endfunction

    // Carrier tick is a phase accumulator, since 13.56 MHz does not
    // divide 40 MHz evenly; ticks jitter by one cycle but average exact.
    localparam logic [CRT_ACC_W-1:0] ACC_STEP = CRT_ACC_W'(CRT_CARRIER_KHZ);
    localparam logic [CRT_ACC_W-1:0] ACC_MOD = CRT_ACC_W'(CRT_CLK_KHZ);
    localparam int SLOW_W = $clog2(SLOW_DIV + 1);
    localparam logic [SLOW_W-1:0] SLOW_LAST = SLOW_W'(SLOW_DIV - 1);

    logic [CRT_ACC_W-1:0] acc_r; // Carrier phase accumulator.
    logic carrier_en_r; // One-cycle carrier tick.
    logic [SLOW_W-1:0] slow_cnt_r; // Carrier ticks toward a slow tick.
    logic slow_en_r; // One-cycle divided-clock tick.

    logic aw_full_r, w_full_r; // Write address and data are latched.
    logic [7:0] aw_idx_r; // Latched write index.
    logic [7:0] w_byte_r; // Latched write byte lane 0.
    logic w_lane0_r; // Byte lane 0 was strobed.
    logic do_write; // Both halves present, response slot free.
    logic [7:0] rd_idx; // Index of the read being answered.

    crt_ctrl_t ctrl_r; // Second timer control.
    logic [TMR_W-1:0] reload_r; // Reload value, both bytes.
    logic [TMR_W-1:0] cnt_r, cnt_nxt; // Live count.
    logic run_r, run_nxt; // Running flag.
    logic flag_r; // Sticky underflow flag.
    crt_ctrl_t t2_ctrl_r; // Third timer control, stored only.

    logic [2:0] trim_sync_r; // Three-stage trim reference synchroniser.
    logic trim_lvl_r; // Accepted trim reference level.
    logic trim_rise; // Accepted rising edge.

    logic tick; // Selected count tick.
    logic start_ev; // Any start event this cycle.
    logic uflow; // Counter passes zero this cycle.
    logic glob_wr, flag_wr; // Writes to the own registers.
    logic trim_mode;

    // Carrier and slow tick generators.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= '0;
            carrier_en_r <= 1'b0;
        end else if (acc_r + ACC_STEP >= ACC_MOD) begin
            acc_r <= acc_r + ACC_STEP - ACC_MOD;
            carrier_en_r <= 1'b1;
        end else begin
            acc_r <= acc_r + ACC_STEP;
            carrier_en_r <= 1'b0;
        end
    end

    // The slow tick is every SLOW_DIV-th carrier tick.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_cnt_r <= '0;
            slow_en_r <= 1'b0;
        end else begin
            slow_en_r <= 1'b0;
            if (carrier_en_r) begin
                if (slow_cnt_r == SLOW_LAST) begin
                    slow_cnt_r <= '0;
                    slow_en_r <= 1'b1;
                end else begin
                    slow_cnt_r <= slow_cnt_r + 1'b1;
                end
            end
        end
    end

    // Trim reference crosses in; an edge counts once stages two and
    // three agree, so a single metastable sample cannot make one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_sync_r <= '0;
            trim_lvl_r <= 1'b0;
        end else begin
            trim_sync_r <= {trim_sync_r[1:0], trim_ref};
            if (trim_sync_r[1] == trim_sync_r[2]) begin
                trim_lvl_r <= trim_sync_r[2];
            end
        end
    end

    assign trim_rise = (trim_sync_r[1] == trim_sync_r[2]) &&
        trim_sync_r[2] && !trim_lvl_r;

    // Write address and write data are taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            aw_idx_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_idx_r <= reg_index(s_axi_awaddr);
        end else if (do_write) begin
            aw_full_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_r <= 1'b0;
            w_byte_r <= '0;
            w_lane0_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_lane0_r <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_full_r <= 1'b0;
        end
    end

    assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;
    assign glob_wr = do_write && w_lane0_r && aw_idx_r == CRT_IDX_GLOBAL;
    assign flag_wr = do_write && w_lane0_r && aw_idx_r == CRT_IDX_FLAGS;

    // Ready is offered only while the matching holding slot is empty.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !(aw_full_r || (s_axi_awvalid &&
                s_axi_awready)) || do_write;
            s_axi_wready <= !(w_full_r || (s_axi_wvalid &&
                s_axi_wready)) || do_write;
        end
    end

    // Write response; unmapped indices answer with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CRT_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= reg_mapped(aw_idx_r) ? CRT_RESP_OKAY :
                CRT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control and reload registers; reserved bits are kept at zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CRT_CTRL_RST;
            t2_ctrl_r <= CRT_CTRL_RST;
            reload_r <= CRT_RELOAD_RST;
        end else if (do_write && w_lane0_r) begin
            case (aw_idx_r)
                CRT_IDX_T1_CTRL: ctrl_r <= w_byte_r & 8'hBB;
                CRT_IDX_T2_CTRL: t2_ctrl_r <= w_byte_r & 8'hBB;
                CRT_IDX_T1_RLD_HI: reload_r[15:8] <= w_byte_r;
                CRT_IDX_T1_RLD_LO: reload_r[7:0] <= w_byte_r;
                default: ;
            endcase
        end
    end

    assign trim_mode = ctrl_r.start_mode_field[1];

    // Tick selection from the clock source field.
    always_comb begin
        case (ctrl_r.clock_source_field)
            CRT_CLK_CARRIER: tick = carrier_en_r;
            CRT_CLK_SLOW: tick = slow_en_r;
            CRT_CLK_PREV_UF: tick = events.first_timer_underflow;
            CRT_CLK_NEXT_UF: tick = events.third_timer_underflow;
            default: tick = 1'b0;
        endcase
    end

    // Count, start, stop and underflow. Software writes to the running
    // flag come last and so win over hardware events in the same cycle.
    always_comb begin
        run_nxt = run_r;
        cnt_nxt = cnt_r;
        start_ev = 1'b0;
        uflow = 1'b0;
        if (run_r && tick) begin
            if (cnt_r != '0) begin
                cnt_nxt = cnt_r - 1'b1;
            end else if (ctrl_r.start_mode_field == CRT_START_TRIM) begin
                cnt_nxt = cnt_r;
            end else begin
                uflow = 1'b1;
                if (ctrl_r.auto_restart_bit) begin
                    cnt_nxt = reload_r;
                end else begin
                    run_nxt = 1'b0;
                end
            end
        end
        if (ctrl_r.stop_on_receive_bit && !trim_mode &&
                events.rx_first_bits) begin
            run_nxt = 1'b0;
        end
        if (ctrl_r.start_mode_field == CRT_START_TX_END && events.tx_end) begin
            start_ev = 1'b1;
        end
        if (trim_mode && trim_rise) begin
            if (run_r) begin
                run_nxt = 1'b0;
            end else begin
                start_ev = 1'b1;
            end
        end
        // A global write without the enable bit leaves the flag alone.
        if (glob_wr && w_byte_r[CRT_BIT_SS_EN]) begin
            run_nxt = w_byte_r[CRT_BIT_RUNNING];
            start_ev = w_byte_r[CRT_BIT_RUNNING];
        end
        if (start_ev) begin
            run_nxt = 1'b1;
            cnt_nxt = reload_r;
        end
    end

    // Counter state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
        end
    end

    // Sticky underflow flag: write one clears, a new underflow wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= 1'b0;
        end else if (uflow) begin
            flag_r <= 1'b1;
        end else if (flag_wr && w_byte_r[CRT_BIT_UF_FLAG]) begin
            flag_r <= 1'b0;
        end
    end

    // Read channel; count bytes are sampled live, so software must not
    // read them mid-reception, where they move under it.
    always_comb begin
        rd_idx = reg_index(s_axi_araddr);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= CRT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= reg_mapped(rd_idx) ? CRT_RESP_OKAY :
                CRT_RESP_SLVERR;
            case (rd_idx)
                CRT_IDX_T0_CNT_LO:
                    s_axi_rdata <= {24'h0, first_timer_count_low_byte};
                CRT_IDX_T1_CTRL: s_axi_rdata <= {24'h0, ctrl_r};
                CRT_IDX_T1_RLD_HI: s_axi_rdata <= {24'h0, reload_r[15:8]};
                CRT_IDX_T1_RLD_LO: s_axi_rdata <= {24'h0, reload_r[7:0]};
                CRT_IDX_T1_CNT_HI:
                    s_axi_rdata <= {24'h0, cnt_r[15:8]};
                CRT_IDX_T1_CNT_LO:
                    s_axi_rdata <= {24'h0, cnt_r[7:0]};
                CRT_IDX_T2_CTRL: s_axi_rdata <= {24'h0, t2_ctrl_r};
                CRT_IDX_GLOBAL: s_axi_rdata <= {26'h0, run_r, 5'h00};
                CRT_IDX_FLAGS: s_axi_rdata <= {31'h0, flag_r};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Outputs, each from a flip-flop.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            second_timer_underflow_flag <= 1'b0;
            second_timer_running_flag <= 1'b0;
            second_timer_underflow_pulse <= 1'b0;
            third_timer_control <= CRT_CTRL_RST;
        end else begin
            second_timer_underflow_flag <= flag_r;
            second_timer_running_flag <= run_r;
            second_timer_underflow_pulse <= uflow;
            third_timer_control <= t2_ctrl_r;
        end
    end

    // Checks on the timer behaviour.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_no_sw;
        !glob_wr;
    endsequence

    sequence s_rx_stop;
        run_r && ctrl_r.stop_on_receive_bit && !trim_mode &&
            events.rx_first_bits && !start_ev;
    endsequence

    sequence s_quiet_run;
        run_r && !start_ev && !uflow && !(trim_mode && trim_rise);
    endsequence

    a_rx_stop_halt: assert property (
        s_rx_stop ##0 s_no_sw |=> !run_r ##1 !second_timer_running_flag)
        else $error("Timer kept running after first received bits.");

    a_rx_no_stop: assert property (
        s_quiet_run ##0 s_no_sw ##0 !ctrl_r.stop_on_receive_bit
        ##0 events.rx_first_bits |=> run_r)
        else $error("Reception stopped timer with stop bit clear.");

    a_trim_ignores_rx: assert property (
        s_quiet_run ##0 s_no_sw ##0 trim_mode ##0 events.rx_first_bits
        |=> run_r)
        else $error("Reception stopped timer in trimming mode.");

    a_tx_end_start: assert property (
        ctrl_r.start_mode_field == CRT_START_TX_END && events.tx_end &&
        !glob_wr |=> run_r && cnt_r == $past(reload_r))
        else $error("End of transmission did not load and start.");

    a_trim_hold_zero: assert property (
        ctrl_r.start_mode_field == CRT_START_TRIM && run_r && tick &&
        cnt_r == '0 && !trim_rise && !glob_wr && !flag_wr
        |=> cnt_r == '0 && run_r ##1 $stable(second_timer_underflow_flag))
        else $error("Trimming without underflow passed zero.");

    a_auto_reload: assert property (
        uflow && ctrl_r.auto_restart_bit && !start_ev && !glob_wr &&
        !(trim_mode && trim_rise) &&
        !(ctrl_r.stop_on_receive_bit && !trim_mode && events.rx_first_bits)
        |=> cnt_r == $past(reload_r) && run_r)
        else $error("Auto restart did not reload the counter.");

    a_one_shot_stop: assert property (
        uflow && !ctrl_r.auto_restart_bit && !start_ev |=>
        !run_r ##1 !second_timer_running_flag)
        else $error("One-shot timer did not stay halted.");

    a_flag_on_uflow: assert property (
        uflow |=> flag_r ##1 second_timer_underflow_flag)
        else $error("Underflow did not set the flag.");

    a_decrement: assert property (
        s_quiet_run ##0 tick && cnt_r != '0 |=> cnt_r == $past(cnt_r) - 1'b1)
        else $error("Running counter did not decrement on tick.");

    a_reload_no_disturb: assert property (
        s_quiet_run ##0 !tick ##0 do_write && aw_idx_r == CRT_IDX_T1_RLD_LO
        |=> $stable(cnt_r))
        else $error("Reload write disturbed the running count.");

    a_sw_needs_enable: assert property (
        glob_wr && !w_byte_r[CRT_BIT_SS_EN] && !run_r && !start_ev
        |=> !run_r)
        else $error("Running flag changed without enable bit.");

endmodule

// file: dv/testbench.sv
`timescale 1ns/10ps
// Register-level bench: bus calls and event pulses, with compares on registers and outputs.
module testbench
    import crt_pkg::*;
;
    logic aclk = 1'h0; // Bench clock, 25 ns period.
    logic aresetn = 1'h0; // Held low for the first 20 cycles.
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF; // Lane 0 always enabled.
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rdat;
    crt_events_t ev = '0; // Frontend event pulses.
    logic [7:0] t0lo = 8'hA5; // First timer count seen at 13h.
    logic trim = 1'h0; // Trimming reference.
    logic uf_flag, run_flag, uf_pulse;
    crt_ctrl_t t2ctl;
    int miscompares = 0;
    int compares = 0;
    int uf_seen = 0; // Underflow pulses counted on the output.

    always #12.5 aclk = ~aclk;

    // Counts one-cycle underflow pulses; a stuck pulse counts every cycle.
    always @(posedge aclk) begin
        if (uf_pulse === 1'b1) uf_seen <= uf_seen + 1;
    end

    // A short slow divider keeps the divided-clock test brief.
    crt_timer #(.TMR_W(16), .SLOW_DIV(2)) i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .events(ev), .first_timer_count_low_byte(t0lo), .trim_ref(trim),
        .second_timer_underflow_flag(uf_flag),
        .second_timer_running_flag(run_flag),
        .second_timer_underflow_pulse(uf_pulse),
        .third_timer_control(t2ctl)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Case equality, so an unknown never counts as a match.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Write one byte; address and data offered together, released apart.
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge aclk);
        awaddr <= {idx[5:0], 2'h0};
        wdata <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        rsp = bresp;
        bready <= 1'h0;
        // A wait that runs out is a failure in its own right.
        if (n == 100) begin
            miscompares++;
            test_done();
        end
    endtask

    // Read one word; data and response are taken at the rvalid edge.
    task automatic rd(input logic [7:0] idx);
        int n;
        @(posedge aclk);
        araddr <= {idx[5:0], 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rdat = rdata;
        rsp = rresp;
        rready <= 1'h0;
        if (n == 100) begin
            miscompares++;
            test_done();
        end
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        rd(idx);
        chk(rdat, exp);
    endtask

    // One-cycle event pulses with room for the lagging outputs to settle.
    // Counts are read only once a pulse has passed, never mid-frame
    task automatic pulse(input crt_events_t e, input int k);
        repeat (k) begin
            @(posedge aclk);
            ev <= e;
            @(posedge aclk);
            ev <= '0;
            repeat (3) @(posedge aclk);
        end
    endtask

    // One rising edge of the reference; the synchroniser costs 3 cycles.
    task automatic trim_edge();
        @(posedge aclk);
        trim <= 1'h1;
        repeat (7) @(posedge aclk);
        trim <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask

    initial begin
        logic [7:0] i;
        int s;
        logic ok;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        // Registers 14h to 19h are all zero after reset.
        for (i = 8'h14; i <= 8'h19; i++) rdchk(i, 32'h0);
        wr(CRT_IDX_T1_RLD_HI, 8'h12);
        wr(CRT_IDX_T1_RLD_LO, 8'h34);
        rdchk(CRT_IDX_T1_RLD_HI, 32'h12);
        rdchk(CRT_IDX_T1_RLD_LO, 32'h34);
        // Reserved bits 6 and 2 never hold a one.
        wr(CRT_IDX_T1_CTRL, 8'hFF);
        rdchk(CRT_IDX_T1_CTRL, 32'hBB);
        wr(CRT_IDX_T2_CTRL, 8'hFF);
        rdchk(CRT_IDX_T2_CTRL, 32'hBB);
        chk(t2ctl, 32'hBB);
        wr(CRT_IDX_T1_CNT_HI, 8'h55);
        rdchk(CRT_IDX_T1_CNT_HI, 32'h0);
        rdchk(CRT_IDX_T0_CNT_LO, 32'hA5);
        t0lo <= 8'h5A;
        rdchk(CRT_IDX_T0_CNT_LO, 32'h5A);
        // An unmapped index is refused on both paths.
        wr(8'h30, 8'h01);
        chk(rsp, CRT_RESP_SLVERR);
        rd(8'h30);
        chk(rsp, CRT_RESP_SLVERR);
        chk(rdat, 32'h0);
        $display("test access finished");
        // One-shot count of 3 on first-timer underflows.
        wr(CRT_IDX_T1_CTRL, 8'h02);
        wr(CRT_IDX_T1_RLD_HI, 8'h00);
        wr(CRT_IDX_T1_RLD_LO, 8'h03);
        wr(CRT_IDX_GLOBAL, 8'h22);
        rdchk(CRT_IDX_T1_CNT_LO, 32'h3);
        pulse(4'h2, 2);
        rdchk(CRT_IDX_T1_CNT_LO, 32'h1);
        pulse(4'h1, 1);
        rdchk(CRT_IDX_T1_CNT_LO, 32'h1);
        pulse(4'h2, 2);
        rdchk(CRT_IDX_T1_CNT_LO, 32'h0);
        chk(uf_flag, 32'h1);
        chk(run_flag, 32'h0);
        // Without the enable bit the running flag must not move.
        wr(CRT_IDX_GLOBAL, 8'h20);
        repeat (3) @(posedge aclk);
        chk(run_flag, 32'h0);
        wr(CRT_IDX_FLAGS, 8'h01);
        rdchk(CRT_IDX_FLAGS, 32'h0);
        chk(uf_seen, 32'h1);
        $display("test one_shot finished");
        // Auto-restart on third-timer underflows, then a reload rewrite.
        wr(CRT_IDX_T1_CTRL, 8'h0B);
        wr(CRT_IDX_GLOBAL, 8'h22);
        pulse(4'h1, 4);
        rdchk(CRT_IDX_T1_CNT_LO, 32'h3);
        chk(uf_flag, 32'h1);
        chk(run_flag, 32'h1);
        wr(CRT_IDX_T1_RLD_LO, 8'h05);
        pulse(4'h1, 1);
        rdchk(CRT_IDX_T1_CNT_LO, 32'h2);
        wr(CRT_IDX_GLOBAL, 8'h02);
        $display("test auto_restart finished");
        // Mode 00 ignores the end of transmission; mode 01 starts on it.
        wr(CRT_IDX_T1_CTRL, 8'h02);
        pulse(4'h8, 1);
        chk(run_flag, 32'h0);
        for (s = 0; s < 2; s++) begin
            wr(CRT_IDX_T1_CTRL, (s == 1) ? 8'h92 : 8'h12);
            pulse(4'h8, 1);
            rdchk(CRT_IDX_T1_CNT_LO, 32'h5);
            pulse(4'h4, 1);
            chk(run_flag, (s == 1) ? 32'h0 : 32'h1);
            wr(CRT_IDX_GLOBAL, 8'h02);
        end
        $display("test start_stop finished");
        // Trimming modes: edge start, receive stop ignored, underflow or not.
        for (s = 0; s < 2; s++) begin
            wr(CRT_IDX_FLAGS, 8'h01);
            wr(CRT_IDX_T1_CTRL, (s == 1) ? 8'hB2 : 8'hA2);
            trim_edge();
            chk(run_flag, 32'h1);
            pulse(4'h4, 1);
            chk(run_flag, 32'h1);
            pulse(4'h2, 6);
            rdchk(CRT_IDX_T1_CNT_LO, 32'h0);
            chk(uf_flag, (s == 1) ? 32'h1 : 32'h0);
            chk(run_flag, (s == 1) ? 32'h0 : 32'h1);
            if (s == 0) begin
                trim_edge();
                chk(run_flag, 32'h0);
            end
        end
        chk(uf_seen, 32'h3);
        $display("test trimming finished");
        // Carrier and divided clocks: about 0.34 and 0.17 ticks a cycle.
        wr(CRT_IDX_T1_RLD_HI, 8'hFF);
        wr(CRT_IDX_T1_RLD_LO, 8'hFF);
        for (s = 0; s < 2; s++) begin
            wr(CRT_IDX_T1_CTRL, (s == 1) ? 8'h01 : 8'h00);
            wr(CRT_IDX_GLOBAL, 8'h22);
            repeat (100) @(posedge aclk);
            rd(CRT_IDX_T1_CNT_LO);
            ok = (s == 1) ? (rdat >= 32'hE8 && rdat <= 32'hF3)
                          : (rdat >= 32'hD4 && rdat <= 32'hE2);
            chk(ok, 32'h1);
            rdchk(CRT_IDX_T1_CNT_HI, 32'hFF);
            wr(CRT_IDX_GLOBAL, 8'h02);
        end
        $display("test clock_source finished");
        test_done();
    end
endmodule
